// ==== design/cart_map_pkg.sv ====
package cart_map_pkg;

  // ----------------------------------------------------------------
  // Personalities and memory map modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CART_OFF, CART_FASTLOAD, CART_UTILITY, CART_ADDR_GAME, CART_TURBO_W,
    CART_READ_GAME, CART_SPLIT, CART_BANK64, CART_SNAPSHOT, CART_LANGUAGE,
    CART_TWOBANK, CART_ASSEMBLER, CART_KERNREP, CART_FLASH, CART_INVISIBLE,
    CART_MUSIC
  } cart_type;

  // Order matches the flash mode field: off, overlay, 8K, 16K
  typedef enum logic [1:0] {MAP_OFF, MAP_ULTI, MAP_8K, MAP_16K} map_type;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAGE_IO1                   = 8'hDE;
  localparam logic [7:0]  PAGE_IO2                   = 8'hDF;
  localparam logic [2:0]  WIN_ROML                   = 3'h4;
  localparam logic [2:0]  WIN_ROMH                   = 3'h5;
  localparam logic [2:0]  WIN_ROME                   = 3'h7;
  localparam logic [2:0]  WIN_RAM6                   = 3'h3;
  localparam logic [15:0] FREEZER_BANK_AND_MODE_OFS  = 16'hDE00;
  localparam logic [15:0] FREEZER_ALIAS_OFS          = 16'hDE01;
  localparam logic [15:0] FLASH_BANK_SELECT_OFS      = 16'hDE00;
  localparam logic [15:0] FLASH_MODE_CONTROL_OFS     = 16'hDE02;
  localparam logic [15:0] SIXTY_FOUR_BANK_SELECT_OFS = 16'hDF00;
  localparam logic [15:0] MUSIC_TOOLS_BANK_SELECT_OFS = 16'hDF00;
  localparam logic [15:0] INV_OFF_ADDR               = 16'hFFF7;
  localparam logic [15:0] INV_ON_ADDR                = 16'hFFF8;

  // ----------------------------------------------------------------
  // Fields, mirrors and counts
  // ----------------------------------------------------------------
  localparam int          BANK_W          = 7;
  localparam logic [3:0]  MIRROR_512_HI   = 4'hF;
  localparam logic [4:0]  MIRROR_256_HI   = 5'h1F;
  localparam logic [5:0]  LANG_VAL_HI     = 6'h20;
  localparam int          B64_OFF_BIT     = 7;
  localparam int          MUS_OFF_BIT     = 5;
  localparam int          SNAP_BANK_HI    = 4;
  localparam int          SNAP_BANK_LO    = 2;
  localparam int          FL_IDLE_CYCLES  = 512;
  localparam int          RC_STEP         = 16;
  localparam int          RC_LIMIT        = 512;
  localparam int          RC_W            = 10;
  localparam int          FLASH_RAM_BYTES = 256;
  localparam map_type     MAP_RESET       = MAP_ULTI;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps
// Two-stage synchroniser for a level from a pin
module pin_sync
  import cart_map_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);

  logic meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      level   <= 1'b0;
    end else begin
      meta_ff <= pin;
      level   <= meta_ff;
    end
  end

endmodule

// ==== design/rc_filter.sv ====
`timescale 1ns/10ps
// Charge/decay counter standing in for an RC low-pass on a control line
module rc_filter
  import cart_map_pkg::*;
#(
  parameter int STEP  = RC_STEP,
  parameter int LIMIT = RC_LIMIT,
  parameter int W     = RC_W
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic hit,
  input  wire logic clr,
  output logic      reached
);

  localparam logic [W:0] STEP_V  = (W+1)'(STEP);
  localparam logic [W:0] LIMIT_V = (W+1)'(LIMIT);

  logic [W-1:0] cnt_ff;
  logic [W:0]   sum;

  assign sum     = {1'b0, cnt_ff} + STEP_V;
  assign reached = ({1'b0, cnt_ff} >= LIMIT_V);

  // Saturate at the limit so a long burst cannot wrap
  always_ff @(posedge mclk) begin
    if (!nrst || clr) begin
      cnt_ff <= '0;
    end else if (hit) begin
      cnt_ff <= (sum >= LIMIT_V) ? LIMIT_V[W-1:0] : sum[W-1:0];
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

// ==== design/cartridge_bank_mapper.sv ====
`timescale 1ns/10ps
// Function
// [RULE_01] Only the personality chosen by the configuration input is active.
// [RULE_02] Timed fastload: DExx read turns 8K ROM on, ROML reads keep it.
// [RULE_03] Timed fastload: ROM off after 512 cycles without such access.
// [RULE_04] Utility: 16K after reset, any DFxx read drops to 8K.
// [RULE_05] Address game: write DE00+n picks bank n; DExx read or reset bank 0.
// [RULE_06] Write turbo: DExx write enables, DFxx write disables; 9E00 mirror.
// [RULE_07] Read game: read DE00+n picks 8K bank n of 16; reset bank 0.
// [RULE_08] Split ROM: 4K twice at 8000; 8xxx/9xxx reads pick upper bank.
// [RULE_09] 64 bank: DF00 bits 5-0 pick bank, bit 7 set turns cart off.
// [RULE_10] Snapshot freezer: writes to DE00 or DE01 update bank and mode.
// [RULE_11] Snapshot mode field: overlay, 16K, 8K, or off.
// [RULE_12] Snapshot bank bits 4 and 2 pick RAM and ROM bank; bit 3 ignored.
// [RULE_13] Snapshot freeze forces overlay; DFxx access clears; DFxx reads ROM.
// [RULE_14] Language: write 80-83 hex to DExx picks 16K bank 0-3.
// [RULE_15] Two bank: DExx read picks second 16K bank, DFxx read disables.
// [RULE_16] Assembler: 8K ROM plus last 512 bytes mirrored in DE00-DFFF.
// [RULE_17] Replacement ROM: add 16 per page read, decay 1; 512 switches.
// [RULE_18] Flash: bank and mode registers are write only.
// [RULE_19] Flash: leaves reset in the overlay mode.
// [RULE_20] Flash: 256 byte RAM answers in DFxx at all times.
// [RULE_21] Invisible freezer off at reset; freeze gives overlay ROM and RAM 6000.
// [RULE_22] After a freeze, FFF7 access disables and FFF8 access enables.
// [RULE_23] Music tools: DFxx write picks one of 32 8K blocks.
module cartridge_bank_mapper
  import cart_map_pkg::*;
#(
  parameter int IDLE_CYCLES = FL_IDLE_CYCLES
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire cart_type     cart_sel,
  input  wire logic         bus_act,
  input  wire logic         bus_rnw,
  input  wire logic [15:0]  bus_addr,
  input  wire logic [7:0]   bus_wdata,
  input  wire logic         freeze_btn,
  output logic              game_n,
  output logic              exrom_n,
  output logic              rom_cs,
  output logic [19:0]       rom_addr,
  output logic              ram_cs,
  output logic              ram_we,
  output logic [14:0]       ram_addr,
  output logic [7:0]        io_dout,
  output logic              io_dout_oe
);

  localparam logic [RC_W-1:0] FL_LAST = RC_W'(IDLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] unit_addr(input logic [BANK_W-1:0] unit,
                                            input logic [12:0] ofs);
    unit_addr = {unit, ofs};
  endfunction

  // Freezer mode field order differs from the map enum
  function automatic map_type snap_map(input logic [1:0] fld);
    case (fld)
      2'h0:    snap_map = MAP_ULTI;
      2'h1:    snap_map = MAP_16K;
      2'h2:    snap_map = MAP_8K;
      default: snap_map = MAP_OFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic rd, wr, io1, io2, in_roml, in_romh, in_rome, in_ram6;

  assign rd      = bus_act & bus_rnw;
  assign wr      = bus_act & ~bus_rnw;
  assign io1     = (bus_addr[15:8] == PAGE_IO1);
  assign io2     = (bus_addr[15:8] == PAGE_IO2);
  assign in_roml = (bus_addr[15:13] == WIN_ROML);
  assign in_romh = (bus_addr[15:13] == WIN_ROMH);
  assign in_rome = (bus_addr[15:13] == WIN_ROME);
  assign in_ram6 = (bus_addr[15:13] == WIN_RAM6);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] bank_ff;
  logic              rom_on_ff;
  logic              mode16_ff;
  map_type           map_ff;
  logic              freeze_ff;
  logic              armed_ff;
  logic [RC_W-1:0]   fl_cnt_ff;
  logic              frz_d_ff;
  logic [7:0]        flash_mem_ff [FLASH_RAM_BYTES];
  logic              frz_s, freeze_rise, en_hit, dis_hit;
  logic              fl_touch;
  map_type           cur_map;

  // Freeze button is a pin: synchronise before the edge detector
  pin_sync u_frz (
    .mclk  (mclk),
    .nrst  (nrst),
    .pin   (freeze_btn),
    .level (frz_s)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      frz_d_ff <= 1'b0;
    end else begin
      frz_d_ff <= frz_s;
    end
  end

  assign freeze_rise = frz_s & ~frz_d_ff;

  // Page-read filters; each switch empties the opposite filter
  rc_filter u_en (
    .mclk    (mclk),
    .nrst    (nrst),
    .hit     ((cart_sel == CART_KERNREP) & rd & io1), // RULE_17
    .clr     (dis_hit),
    .reached (en_hit)
  );

  rc_filter u_dis (
    .mclk    (mclk),
    .nrst    (nrst),
    .hit     ((cart_sel == CART_KERNREP) & rd & io2), // RULE_17
    .clr     (en_hit),
    .reached (dis_hit)
  );

  // Activating or keep-alive access for the timed ROM
  assign fl_touch = rd & (io1 | (in_roml & rom_on_ff));

  // ----------------------------------------------------------------
  // Bank register, shared by all personalities
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bank_ff <= '0; // RULE_05 RULE_07
    end else begin
      case (cart_sel)
        CART_ADDR_GAME: begin
          if (wr && io1) begin
            bank_ff <= bus_addr[BANK_W-1:0]; // RULE_05
          end else if (rd && io1) begin
            bank_ff <= '0; // RULE_05
          end
        end
        CART_READ_GAME: begin
          if (rd && io1) begin
            bank_ff <= {3'h0, bus_addr[3:0]}; // RULE_07
          end
        end
        CART_SPLIT: begin
          if (rd && in_roml) begin
            bank_ff <= {6'h00, bus_addr[12]}; // RULE_08
          end
        end
        CART_BANK64: begin
          if (wr && io2) begin
            bank_ff <= {1'b0, bus_wdata[5:0]}; // RULE_09
          end
        end
        CART_SNAPSHOT: begin
          if (wr && (bus_addr == FREEZER_BANK_AND_MODE_OFS ||
                     bus_addr == FREEZER_ALIAS_OFS)) begin // RULE_10
            // Bit 3 is deliberately dropped
            bank_ff <= {5'h00, bus_wdata[SNAP_BANK_HI], bus_wdata[SNAP_BANK_LO]}; // RULE_12
          end
        end
        CART_LANGUAGE: begin
          if (wr && io1 && bus_wdata[7:2] == LANG_VAL_HI) begin
            bank_ff <= {5'h00, bus_wdata[1:0]}; // RULE_14
          end
        end
        CART_TWOBANK: begin
          if (rd && io1) begin
            bank_ff <= 7'h01; // RULE_15
          end
        end
        CART_FLASH: begin
          if (wr && bus_addr == FLASH_BANK_SELECT_OFS) begin
            bank_ff <= {1'b0, bus_wdata[5:0]};
          end
        end
        CART_MUSIC: begin
          if (wr && io2) begin
            bank_ff <= {2'h0, bus_wdata[4:0]}; // RULE_23
          end
        end
        default: begin
          bank_ff <= bank_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ROM enable
  // ----------------------------------------------------------------
  // Reset value depends on the personality; sync reset may read the input
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rom_on_ff <= !(cart_sel == CART_INVISIBLE || cart_sel == CART_KERNREP); // RULE_21
    end else begin
      case (cart_sel)
        CART_FASTLOAD: begin
          if (rd && io1) begin
            rom_on_ff <= 1'b1; // RULE_02
          end else if (rom_on_ff && !fl_touch && fl_cnt_ff == FL_LAST) begin
            rom_on_ff <= 1'b0; // RULE_03
          end
        end
        CART_TURBO_W: begin
          if (wr && io1) begin
            rom_on_ff <= 1'b1; // RULE_06
          end else if (wr && io2) begin
            rom_on_ff <= 1'b0; // RULE_06
          end
        end
        CART_BANK64: begin
          if (wr && io2) begin
            rom_on_ff <= ~bus_wdata[B64_OFF_BIT]; // RULE_09
          end
        end
        CART_MUSIC: begin
          if (wr && io2) begin
            rom_on_ff <= ~bus_wdata[MUS_OFF_BIT];
          end
        end
        CART_TWOBANK: begin
          if (rd && io2) begin
            rom_on_ff <= 1'b0; // RULE_15
          end
        end
        CART_KERNREP: begin
          if (en_hit) begin
            rom_on_ff <= 1'b1; // RULE_17
          end else if (dis_hit) begin
            rom_on_ff <= 1'b0; // RULE_17
          end
        end
        CART_INVISIBLE: begin
          if (freeze_rise) begin
            rom_on_ff <= 1'b1; // RULE_21
          end else if (armed_ff && bus_act && bus_addr == INV_OFF_ADDR) begin
            rom_on_ff <= 1'b0; // RULE_22
          end else if (armed_ff && bus_act && bus_addr == INV_ON_ADDR) begin
            rom_on_ff <= 1'b1; // RULE_22
          end
        end
        default: begin
          rom_on_ff <= rom_on_ff;
        end
      endcase
    end
  end

  // Idle counter of the timed ROM; any touch restarts it
  always_ff @(posedge mclk) begin
    if (!nrst || cart_sel != CART_FASTLOAD || !rom_on_ff || fl_touch) begin
      fl_cnt_ff <= '0;
    end else if (fl_cnt_ff != FL_LAST) begin
      fl_cnt_ff <= fl_cnt_ff + 1'b1; // RULE_03
    end
  end

  // Utility 16K/8K mode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode16_ff <= 1'b1; // RULE_04
    end else if (cart_sel == CART_UTILITY && rd && io2) begin
      mode16_ff <= 1'b0; // RULE_04
    end
  end

  // Mode field of the freezer and flash personalities
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      map_ff <= MAP_RESET; // RULE_19
    end else if (cart_sel == CART_SNAPSHOT && wr &&
                 (bus_addr == FREEZER_BANK_AND_MODE_OFS ||
                  bus_addr == FREEZER_ALIAS_OFS)) begin
      map_ff <= snap_map(bus_wdata[1:0]); // RULE_10 RULE_11
    end else if (cart_sel == CART_FLASH && wr && bus_addr == FLASH_MODE_CONTROL_OFS) begin
      map_ff <= map_type'(bus_wdata[1:0]);
    end
  end

  // Freeze latch: a freeze in the clearing cycle still wins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      freeze_ff <= 1'b0;
    end else if (cart_sel == CART_SNAPSHOT && freeze_rise) begin
      freeze_ff <= 1'b1; // RULE_13
    end else if (bus_act && io2) begin
      freeze_ff <= 1'b0; // RULE_13
    end
  end

  // Enable/disable addresses live from first freeze until reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      armed_ff <= 1'b0;
    end else if (cart_sel == CART_INVISIBLE && freeze_rise) begin
      armed_ff <= 1'b1; // RULE_22
    end
  end

  // Flash RAM page; no reset, it is plain storage
  always_ff @(posedge mclk) begin
    if (cart_sel == CART_FLASH && wr && io2) begin
      flash_mem_ff[bus_addr[7:0]] <= bus_wdata; // RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Memory map of the active personality
  // ----------------------------------------------------------------
  always_comb begin
    case (cart_sel) // RULE_01
      CART_FASTLOAD, CART_BANK64, CART_MUSIC, CART_KERNREP:
        cur_map = rom_on_ff ? MAP_8K : MAP_OFF;
      CART_UTILITY:   cur_map = mode16_ff ? MAP_16K : MAP_8K; // RULE_04
      CART_ADDR_GAME, CART_READ_GAME, CART_ASSEMBLER:
        cur_map = MAP_8K; // RULE_16
      CART_TURBO_W, CART_TWOBANK:
        cur_map = rom_on_ff ? MAP_16K : MAP_OFF;
      CART_SPLIT, CART_LANGUAGE: cur_map = MAP_16K;
      CART_SNAPSHOT:  cur_map = freeze_ff ? MAP_ULTI : map_ff; // RULE_13
      CART_FLASH:     cur_map = map_ff;
      CART_INVISIBLE: cur_map = rom_on_ff ? MAP_ULTI : MAP_OFF; // RULE_21
      default:        cur_map = MAP_OFF;
    endcase
  end

  // Cartridge control lines follow the map
  assign game_n  = !(cur_map == MAP_16K || cur_map == MAP_ULTI);
  assign exrom_n = !(cur_map == MAP_16K || cur_map == MAP_8K);

  // ----------------------------------------------------------------
  // ROM, RAM and I/O responses
  // ----------------------------------------------------------------
  always_comb begin
    logic [BANK_W-1:0] lo_u;
    logic [BANK_W-1:0] hi_u;
    lo_u     = bank_ff;
    hi_u     = bank_ff;
    rom_cs   = 1'b0;
    rom_addr = '0;
    ram_cs   = 1'b0;
    ram_addr = '0;
    // 16K-bank personalities pair two 8K units
    case (cart_sel)
      CART_UTILITY, CART_TURBO_W, CART_LANGUAGE, CART_TWOBANK,
      CART_SNAPSHOT, CART_FLASH: begin
        lo_u = {bank_ff[BANK_W-2:0], 1'b0};
        hi_u = {bank_ff[BANK_W-2:0], 1'b1};
      end
      CART_SPLIT: begin
        lo_u = '0; // RULE_08
        hi_u = bank_ff + 7'h01; // RULE_08
      end
      CART_INVISIBLE: begin
        lo_u = '0;
        hi_u = '0;
      end
      default: begin
        lo_u = bank_ff;
        hi_u = bank_ff;
      end
    endcase
    if (cart_sel == CART_SPLIT && in_roml) begin
      // 4K image appears twice; upper 4K of the unit is a copy
      rom_cs   = rd;
      rom_addr = unit_addr(lo_u, {1'b0, bus_addr[11:0]}); // RULE_08
    end else if (in_roml && cur_map == MAP_ULTI && cart_sel == CART_SNAPSHOT) begin
      ram_cs   = bus_act;
      ram_addr = {bank_ff[1:0], bus_addr[12:0]}; // RULE_11 RULE_12
    end else if (in_roml && cur_map != MAP_OFF) begin
      rom_cs   = rd;
      rom_addr = unit_addr(lo_u, bus_addr[12:0]);
    end else if ((in_romh && cur_map == MAP_16K) || (in_rome && cur_map == MAP_ULTI)) begin
      rom_cs   = rd;
      rom_addr = unit_addr(hi_u, bus_addr[12:0]); // RULE_11 RULE_21
    end else if (in_ram6 && cart_sel == CART_INVISIBLE && rom_on_ff) begin
      ram_cs   = bus_act;
      ram_addr = {2'h0, bus_addr[12:0]}; // RULE_21
    end else if (cart_sel == CART_FASTLOAD && io2) begin
      rom_cs   = rd;
      rom_addr = unit_addr('0, {MIRROR_256_HI, bus_addr[7:0]}); // RULE_02
    end else if ((cart_sel == CART_TURBO_W || cart_sel == CART_ASSEMBLER) &&
                 (io1 || io2)) begin
      rom_cs   = rd;
      rom_addr = unit_addr('0, {MIRROR_512_HI, bus_addr[8:0]}); // RULE_06 RULE_16
    end else if (cart_sel == CART_SNAPSHOT && io2) begin
      rom_cs   = rd;
      rom_addr = unit_addr(lo_u, {MIRROR_256_HI, bus_addr[7:0]}); // RULE_13
    end
  end

  assign ram_we     = ram_cs & ~bus_rnw;
  // Only the RAM page answers reads; bank and mode stay invisible
  assign io_dout_oe = (cart_sel == CART_FLASH) & rd & io2; // RULE_18 RULE_20
  assign io_dout    = io_dout_oe ? flash_mem_ff[bus_addr[7:0]] : 8'h00;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  fastload_act_a: assert property ((cart_sel == CART_FASTLOAD) && rd && io1 // RULE_02
    |=> rom_on_ff && !exrom_n) else $error("timed rom not switched on");
  fastload_off_a: assert property ((cart_sel == CART_FASTLOAD) && rom_on_ff // RULE_03
    && fl_cnt_ff == FL_LAST && !fl_touch |=> !rom_on_ff && exrom_n)
    else $error("timed rom not switched off at limit");
  fastload_hold_a: assert property ((cart_sel == CART_FASTLOAD) && fl_touch // RULE_03
    && rom_on_ff |=> rom_on_ff && fl_cnt_ff == '0)
    else $error("keep-alive read did not restart timer");
  utility_8k_a: assert property ((cart_sel == CART_UTILITY) && rd && io2 // RULE_04
    |=> (!mode16_ff && game_n)[*3]) else $error("utility did not drop to 8K");
  addr_game_a: assert property ((cart_sel == CART_ADDR_GAME) && wr && io1 // RULE_05
    |=> bank_ff == $past(bus_addr[BANK_W-1:0])) else $error("bank not taken from address");
  turbo_toggle_a: assert property ((cart_sel == CART_TURBO_W) && wr && io2 // RULE_06
    |=> game_n && exrom_n) else $error("turbo rom not disabled");
  read_game_a: assert property ((cart_sel == CART_READ_GAME) && rd && io1 // RULE_07
    |=> bank_ff[3:0] == $past(bus_addr[3:0])) else $error("read bank select wrong");
  bank64_off_a: assert property ((cart_sel == CART_BANK64) && wr && io2 // RULE_09
    |=> rom_on_ff == !$past(bus_wdata[B64_OFF_BIT])) else $error("bank64 enable wrong");
  snap_freeze_a: assert property ((cart_sel == CART_SNAPSHOT) && freeze_rise // RULE_13
    |=> !game_n && exrom_n) else $error("freeze did not force overlay");
  flash_hidden_a: assert property ((cart_sel == CART_FLASH) && io1 |-> !io_dout_oe) // RULE_18
    else $error("write-only register answered a read");
  flash_ram_a: assert property ((cart_sel == CART_FLASH) && rd && io2 |-> io_dout_oe) // RULE_20
    else $error("flash RAM page did not answer");
  inv_kill_a: assert property ((cart_sel == CART_INVISIBLE) && armed_ff && bus_act // RULE_22
    && bus_addr == INV_OFF_ADDR && !freeze_rise |=> game_n && exrom_n)
    else $error("invisible freezer not disabled");

  fastload_timeout_c: cover property ((cart_sel == CART_FASTLOAD) && rom_on_ff ##1 !rom_on_ff);
  snap_unfreeze_c: cover property (freeze_ff && bus_act && io2 ##1 !freeze_ff);
  kern_switch_c: cover property ((cart_sel == CART_KERNREP) && en_hit);
  inv_reenable_c: cover property (armed_ff && !rom_on_ff ##1 rom_on_ff);

endmodule

// ==== sim/cpu_bus_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Processor on the expansion bus
// ----------------------------------------
module cpu_bus_model (
  input  wire logic        mclk,
  output logic             bus_act,
  output logic             bus_rnw,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_wdata
);
  // Bus idles inactive from time zero
  initial begin
    bus_act = 1'b0;
    bus_rnw = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
  end
  // One cycle, launched on the falling edge; settled 1 ns later
  task automatic cyc(input logic act, input logic rnw, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    bus_act = act;
    bus_rnw = rnw;
    bus_addr = act ? a : ~bus_addr;
    bus_wdata = act ? d : ~bus_wdata;
    #1;
  endtask
endmodule

// ==== sim/cartridge_bank_mapper_test.sv ====
`timescale 1ns/10ps
module cartridge_bank_mapper_test
  import cart_map_pkg::*;
;
  // ----------------------------------------
  // Clock, nets and design
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        freeze_btn = 1'b0;
  cart_type    cart_sel = CART_OFF;
  logic        bus_act, bus_rnw, game_n, exrom_n, rom_cs, ram_cs, ram_we, io_oe;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, io_dout;
  logic [19:0] rom_addr;
  logic [14:0] ram_addr;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  always #50 mclk = ~mclk;
  // Short idle count keeps the timeout scenario brief
  localparam int FL_IDLE = 8;
  cartridge_bank_mapper #(.IDLE_CYCLES(FL_IDLE)) i_dut (.mclk(mclk), .nrst(nrst),
    .cart_sel(cart_sel), .bus_act(bus_act), .bus_rnw(bus_rnw), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .freeze_btn(freeze_btn), .game_n(game_n), .exrom_n(exrom_n),
    .rom_cs(rom_cs), .rom_addr(rom_addr), .ram_cs(ram_cs), .ram_we(ram_we),
    .ram_addr(ram_addr), .io_dout(io_dout), .io_dout_oe(io_oe));
  cpu_bus_model i_cpu (.mclk(mclk), .bus_act(bus_act), .bus_rnw(bus_rnw),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic idle;
    i_cpu.cyc(1'b0, 1'b1, 16'h0000, 8'h00);
  endtask
  // Pin held over the two sync stages and the edge detector
  task automatic press;
    freeze_btn = 1'b1;
    repeat (4) idle();
    freeze_btn = 1'b0;
  endtask
  // Personality only changes under reset; bus idles so no stale access follows it
  task automatic start(input cart_type c);
    cart_sel = c;
    nrst = 1'b0;
    idle();
    @(negedge mclk);
    nrst = 1'b1;
  endtask
  task automatic rd(input logic [15:0] a);
    i_cpu.cyc(1'b1, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_cpu.cyc(1'b1, 1'b0, a, d);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_addr_game;
    start(CART_ADDR_GAME);
    rd(16'h8123);
    chk("ag_rst", 20'h00123, rom_addr);
    wr(16'hDE03, 8'h00);
    rd(16'h8123);
    chk("ag_b3", 20'h06123, rom_addr);
    rd(16'hDE40);
    rd(16'h8123);
    chk("ag_b0", 20'h00123, rom_addr);
  endtask
  task automatic t_fastload;
    start(CART_FASTLOAD);
    rd(16'hDE00);
    rd(16'hDF05);
    chk("fl_mirror", 20'h01F05, rom_addr);
    repeat (6) rd(16'h8000);
    chk("fl_on", 20'h1, {19'h0, rom_cs});
    repeat (FL_IDLE - 1) idle();
    rd(16'h8000);
    chk("fl_alive", 20'h1, {19'h0, rom_cs});
    repeat (FL_IDLE) idle();
    rd(16'h8000);
    chk("fl_off", 20'h0, {19'h0, rom_cs});
  endtask
  task automatic t_utility;
    start(CART_UTILITY);
    rd(16'hA000);
    chk("ut_16k", 20'h1, {19'h0, rom_cs});
    rd(16'hDF77);
    rd(16'hA000);
    chk("ut_8k", 20'h0, {19'h0, rom_cs});
  endtask
  task automatic t_bank64;
    start(CART_BANK64);
    wr(16'hDF00, 8'h3F);
    rd(16'h8004);
    chk("b64_bank", 20'h7E004, rom_addr);
    wr(16'hDF00, 8'h80);
    rd(16'h8004);
    chk("b64_off", 20'h0, {19'h0, rom_cs});
  endtask
  task automatic t_language;
    start(CART_LANGUAGE);
    wr(16'hDE55, 8'h82);
    rd(16'h8010);
    chk("lang_b2", 20'h08010, rom_addr);
    wr(16'hDE00, 8'h84);
    rd(16'hA010);
    chk("lang_keep", 20'h0A010, rom_addr);
  endtask
  task automatic t_flash;
    start(CART_FLASH);
    chk("fl_ulti", 20'h1, {18'h0, game_n, exrom_n});
    wr(16'hDF10, 8'h5A);
    rd(16'hDF10);
    chk("fr_ram", 20'h15A, {11'h0, io_oe, io_dout});
    wr(16'hDE02, 8'h00);
    rd(16'hDE02);
    chk("fr_wo", 20'h0, {19'h0, io_oe});
    rd(16'hDF10);
    chk("fr_ram_off", 20'h15A, {11'h0, io_oe, io_dout});
  endtask
  task automatic t_snapshot;
    start(CART_SNAPSHOT);
    wr(16'hDE01, 8'h1D);
    rd(16'hA020);
    chk("ss_bank", 20'h0E020, rom_addr);
    press();
    rd(16'h8040);
    chk("ss_ram", 20'h16040, {3'h0, ram_cs, ram_we, ram_addr});
    rd(16'hDF05);
    chk("ss_io", 20'h0DF05, rom_addr);
    idle();
    chk("ss_unfrz", 20'h0, {18'h0, game_n, exrom_n});
  endtask
  task automatic t_invisible;
    start(CART_INVISIBLE);
    chk("inv_rst", 20'h3, {18'h0, game_n, exrom_n});
    press();
    chk("inv_frz", 20'h1, {18'h0, game_n, exrom_n});
    rd(16'hE010);
    chk("inv_rom", 20'h00010, rom_addr);
    wr(16'h6123, 8'h00);
    chk("inv_ram", 20'h18123, {3'h0, ram_cs, ram_we, ram_addr});
    rd(16'hFFF7);
    idle();
    chk("inv_off", 20'h3, {18'h0, game_n, exrom_n});
    rd(16'hFFF8);
    idle();
    chk("inv_on", 20'h1, {18'h0, game_n, exrom_n});
  endtask
  // ----------------------------------------
  // Run and verdict
  // ----------------------------------------
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard well above the roughly 80 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    t_addr_game();
    t_fastload();
    t_utility();
    t_bank64();
    t_language();
    t_flash();
    t_snapshot();
    t_invisible();
    finish_test();
  end
endmodule
